// >>> verilog/mteis_top.sv
/*
 * edge-select interrupt block for switches 12-14 and 18-21, apb registers.
 * assumes comparator outputs arrive synchronous to pclk.
 */
`timescale 1ns/1ps
`include "mteis_map.svh"
module mteis_top (
	input  wire logic        pclk,                   // 250 mhz clock
	input  wire logic        presetn,                // async reset, low
	input  wire logic        psel,                   // apb select
	input  wire logic        penable,                // apb enable
	input  wire logic        pwrite,                 // apb direction
	input  wire logic [9:0]  paddr,                  // apb byte address
	input  wire logic [31:0] pwdata,                 // apb write data
	output logic [31:0]      prdata,                 // apb read data
	output logic             pready,                 // apb ready
	output logic             pslverr,                // apb error
	input  wire logic [1:0]  switch_twelve,          // above limits a,b
	input  wire logic [1:0]  switch_thirteen,        // above limits a,b
	input  wire logic [1:0]  switch_fourteen,        // above limits a,b
	input  wire logic [2:0]  switch_eighteen,        // above limits a,b,c
	input  wire logic [2:0]  switch_nineteen,        // above limits a,b,c
	input  wire logic [2:0]  switch_twenty,          // above limits a,b,c
	input  wire logic [2:0]  switch_twentyone,       // above limits a,b,c
	output logic             irq                     // level interrupt
);
	logic [`MTEIS_REG_W-1:0]  irq_edge_select_two_level;
	logic [`MTEIS_REG_W-1:0]  irq_edge_select_three_level;
	logic [`MTEIS_NUM_SW-1:0] status;
	logic [`MTEIS_NUM_SW-1:0] mask;
	logic [`MTEIS_NUM_SW-1:0] hit;
	logic                     wr_stb;
	logic                     rd_stb;
	logic [7:0]               index;
	logic                     aligned;
	logic                     mapped;
	logic [31:0]              next_prdata;

	// bus front end
	mteis_apb u_apb (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.wr_stb  (wr_stb),
		.rd_stb  (rd_stb),
		.index   (index),
		.aligned (aligned)
	);

	// two-limit switches
	mteis_crossing #(.LIMITS(2)) u_sw12 (
		.pclk(pclk), .presetn(presetn), .above(switch_twelve),
		.sel(irq_edge_select_two_level[`MTEIS_F12_LO +: 4]), // RULE1 RULE2 RULE3
		.hit(hit[`MTEIS_ST12])
	);
	mteis_crossing #(.LIMITS(2)) u_sw13 (
		.pclk(pclk), .presetn(presetn), .above(switch_thirteen),
		.sel(irq_edge_select_two_level[`MTEIS_F13_LO +: 4]), // RULE3
		.hit(hit[`MTEIS_ST13])
	);
	mteis_crossing #(.LIMITS(2)) u_sw14 (
		.pclk(pclk), .presetn(presetn), .above(switch_fourteen),
		.sel(irq_edge_select_two_level[`MTEIS_F14_LO +: 4]), // RULE3
		.hit(hit[`MTEIS_ST14])
	);

	// three-limit switches
	mteis_crossing #(.LIMITS(3)) u_sw18 (
		.pclk(pclk), .presetn(presetn), .above(switch_eighteen),
		.sel(irq_edge_select_three_level[`MTEIS_F18_LO +: 6]), // RULE6 RULE7 RULE8 RULE10
		.hit(hit[`MTEIS_ST18])
	);
	mteis_crossing #(.LIMITS(3)) u_sw19 (
		.pclk(pclk), .presetn(presetn), .above(switch_nineteen),
		.sel(irq_edge_select_three_level[`MTEIS_F19_LO +: 6]), // RULE10
		.hit(hit[`MTEIS_ST19])
	);
	mteis_crossing #(.LIMITS(3)) u_sw20 (
		.pclk(pclk), .presetn(presetn), .above(switch_twenty),
		.sel(irq_edge_select_three_level[`MTEIS_F20_LO +: 6]), // RULE5
		.hit(hit[`MTEIS_ST20])
	);
	mteis_crossing #(.LIMITS(3)) u_sw21 (
		.pclk(pclk), .presetn(presetn), .above(switch_twentyone),
		.sel(irq_edge_select_three_level[`MTEIS_F21_LO +: 6]), // RULE5
		.hit(hit[`MTEIS_ST21])
	);

	// known register address
	assign mapped = aligned && (index == `MTEIS_IDX_TWO || index == `MTEIS_IDX_THREE ||
		index == `MTEIS_IDX_STATUS || index == `MTEIS_IDX_MASK);

	// two-level select register, upper bits reserved
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_edge_select_two_level <= `MTEIS_RESET_VAL; // RULE9
		else if (wr_stb && aligned && index == `MTEIS_IDX_TWO)
			irq_edge_select_two_level <= {{(`MTEIS_REG_W-`MTEIS_TWO_USED){1'b0}},
				pwdata[`MTEIS_TWO_USED-1:0]};
	end

	// three-level select register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_edge_select_three_level <= `MTEIS_RESET_VAL; // RULE4 RULE9
		else if (wr_stb && aligned && index == `MTEIS_IDX_THREE)
			irq_edge_select_three_level <= pwdata[`MTEIS_REG_W-1:0]; // RULE5
	end

	// mask register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask <= '0;
		else if (wr_stb && aligned && index == `MTEIS_IDX_MASK)
			mask <= pwdata[`MTEIS_NUM_SW-1:0];
	end

	// sticky status, write one clears, a new hit wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status <= '0;
		else if (wr_stb && aligned && index == `MTEIS_IDX_STATUS)
			status <= (status & ~pwdata[`MTEIS_NUM_SW-1:0]) | hit; // RULE12
		else
			status <= status | hit; // RULE12
	end

	// interrupt level from flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(status & mask); // RULE12
	end

	// read mux
	always_comb
	begin
		next_prdata = 32'h00000000;
		if (aligned)
			case (index)
				`MTEIS_IDX_TWO:    next_prdata[`MTEIS_REG_W-1:0] = irq_edge_select_two_level;
				`MTEIS_IDX_THREE:  next_prdata[`MTEIS_REG_W-1:0] = irq_edge_select_three_level;
				`MTEIS_IDX_STATUS: next_prdata[`MTEIS_NUM_SW-1:0] = status;
				`MTEIS_IDX_MASK:   next_prdata[`MTEIS_NUM_SW-1:0] = mask;
				default:           next_prdata = 32'h00000000;
			endcase
	end

	// registered answer: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable) ? next_prdata : prdata;
		end
	end

	// reset leaves every select field zero
	property p_reset_zero;
		@(posedge pclk) $rose(presetn) |-> irq_edge_select_three_level == '0 &&
			irq_edge_select_two_level == '0;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("select not zero"); // RULE9

	// write to 27h lands
	property p_three_write;
		@(posedge pclk) disable iff (!presetn)
			wr_stb && aligned && index == `MTEIS_IDX_THREE |=>
			irq_edge_select_three_level == $past(pwdata[23:0]);
	endproperty
	a_three_write: assert property (p_three_write) else $error("three write lost"); // RULE4

	// rise with rise select sets status
	property p_rise12;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_two_level[1:0] == 2'h1 && $rose(switch_twelve[0]) |=>
			status[`MTEIS_ST12];
	endproperty
	a_rise12: assert property (p_rise12) else $error("rise missed"); // RULE1

	// fall on limit c of switch 21 with fall select
	property p_fall21c;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_three_level[23:22] == 2'h2 && $fell(switch_twentyone[2]) |=>
			status[`MTEIS_ST21];
	endproperty
	a_fall21c: assert property (p_fall21c) else $error("fall missed"); // RULE8

	// no select, no event
	property p_quiet;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_two_level == '0 && irq_edge_select_three_level == '0
			|-> hit == '0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("event while disabled"); // RULE9

	// irq follows unmasked status one cycle later
	property p_irq;
		@(posedge pclk) disable iff (!presetn)
			##1 irq == |($past(status) & $past(mask));
	endproperty
	a_irq: assert property (p_irq) else $error("irq wrong"); // RULE12

	// pready one cycle after setup
	property p_ready;
		@(posedge pclk) disable iff (!presetn) psel && !penable |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready"); // RULE5

	// both select on limit b of switch 19
	property p_both19b;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_three_level[9:8] == 2'h3 && $changed(switch_nineteen[1]) |=>
			status[`MTEIS_ST19];
	endproperty
	a_both19b: assert property (p_both19b) else $error("both missed"); // RULE7

	// switch 13 rise above limit b
	property p_rise13b;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_two_level[7:6] == 2'h1 && $rose(switch_thirteen[1]) |=>
			status[`MTEIS_ST13];
	endproperty
	a_rise13b: assert property (p_rise13b) else $error("limit b rise missed"); // RULE2

	// switch 14 fall below limit a
	property p_fall14a;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_two_level[9:8] == 2'h2 && $fell(switch_fourteen[0]) |=>
			status[`MTEIS_ST14];
	endproperty
	a_fall14a: assert property (p_fall14a) else $error("limit a fall missed"); // RULE3

	// switch 18 rise above limit a
	property p_rise18a;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_three_level[1:0] == 2'h1 && $rose(switch_eighteen[0]) |=>
			status[`MTEIS_ST18];
	endproperty
	a_rise18a: assert property (p_rise18a) else $error("limit a rise missed"); // RULE6

	// switch 20 fall below limit b
	property p_fall20b;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_three_level[15:14] == 2'h2 && $fell(switch_twenty[1]) |=>
			status[`MTEIS_ST20];
	endproperty
	a_fall20b: assert property (p_fall20b) else $error("limit b fall missed"); // RULE7

	// switch 20 rise above limit c
	property p_rise20c;
		@(posedge pclk) disable iff (!presetn)
			irq_edge_select_three_level[17:16] == 2'h1 && $rose(switch_twenty[2]) |=>
			status[`MTEIS_ST20];
	endproperty
	a_rise20c: assert property (p_rise20c) else $error("limit c rise missed"); // RULE5

	// write to 26h lands, reserved bits stay zero
	property p_two_write;
		@(posedge pclk) disable iff (!presetn)
			wr_stb && aligned && index == `MTEIS_IDX_TWO |=> irq_edge_select_two_level ==
			{{(`MTEIS_REG_W-`MTEIS_TWO_USED){1'b0}}, $past(pwdata[`MTEIS_TWO_USED-1:0])};
	endproperty
	a_two_write: assert property (p_two_write) else $error("two write lost"); // RULE3

	// write to the mask lands
	property p_mask_write;
		@(posedge pclk) disable iff (!presetn)
			wr_stb && aligned && index == `MTEIS_IDX_MASK |=>
			mask == $past(pwdata[`MTEIS_NUM_SW-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost");

	// cleared bits read zero when no event competes
	property p_status_clear;
		@(posedge pclk) disable iff (!presetn)
			wr_stb && aligned && index == `MTEIS_IDX_STATUS && hit == '0 |=>
			(status & $past(pwdata[`MTEIS_NUM_SW-1:0])) == '0;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("clear lost"); // RULE12

	// every hit lands in status, even against a clear
	property p_hit_sets;
		@(posedge pclk) disable iff (!presetn)
			hit != '0 |=>
			(status & $past(hit)) == $past(hit);
	endproperty
	a_hit_sets: assert property (p_hit_sets) else $error("hit not latched"); // RULE12

	// status bits stay set until cleared
	property p_status_hold;
		@(posedge pclk) disable iff (!presetn)
			!(wr_stb && aligned && index == `MTEIS_IDX_STATUS) |=>
			(status & $past(status)) == $past(status);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status dropped"); // RULE12

	// error flag marks unmapped or unaligned setups
	property p_slverr;
		@(posedge pclk) disable iff (!presetn)
			psel && !penable |=>
			pslverr == !$past(mapped);
	endproperty
	a_slverr: assert property (p_slverr) else $error("error flag wrong");

	// ready is a one-cycle pulse
	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn)
			pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");

	// read strobe only in the answered access cycle
	property p_read_ready;
		@(posedge pclk) disable iff (!presetn)
			rd_stb |-> pready;
	endproperty
	a_read_ready: assert property (p_read_ready) else $error("read without ready");

	// unmapped writes leave the registers alone
	property p_bad_write;
		@(posedge pclk) disable iff (!presetn)
			wr_stb && !mapped |=> $stable(irq_edge_select_two_level) &&
			$stable(irq_edge_select_three_level) && $stable(mask);
	endproperty
	a_bad_write: assert property (p_bad_write) else $error("stray write landed");

	// fully masked status gives no interrupt
	property p_irq_masked;
		@(posedge pclk) disable iff (!presetn)
			mask == '0 |=> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked irq seen"); // RULE12
endmodule

// >>> pkg/mteis_map.svh
/*
 * register map, field positions and reset values of the edge-select block.
 * assumes a 32-bit apb slave, one aligned word per register.
 */
// Notes on behaviour
// [RULE1] two-level bits 1:0 pick none, rise, fall or both for limit a
// [RULE2] two-level bits 3:2 pick the same choice for limit b independently
// [RULE3] two-level register: switch 14 at 11:8, 13 at 7:4, 12 at 3:0
// [RULE4] three-level register at index 27h, 24 bits wide, resets to zero
// [RULE5] three-level register: switch 21 at 23:18, switch 20 at 17:12, read/write
// [RULE6] three-level bits 1:0 pick none, rise, fall or both for limit a
// [RULE7] three-level bits 3:2 pick the choice for limit b independently
// [RULE8] three-level bits 5:4 pick the choice for limit c
// [RULE9] every select field resets to zero, so no interrupt until enabled
// [RULE10] three-level register: switch 19 at 11:6, switch 18 at 5:0
// [RULE11] rise is not-above to above between samples; fall is the reverse
// [RULE12] any enabled crossing sets a pending event, ored into one request
`ifndef MTEIS_MAP_SVH
`define MTEIS_MAP_SVH

// register indices; byte address is four times the index
`define MTEIS_IDX_TWO     8'h26
`define MTEIS_IDX_THREE   8'h27
`define MTEIS_IDX_STATUS  8'h30
`define MTEIS_IDX_MASK    8'h31
`define MTEIS_REG_W       24
`define MTEIS_RESET_VAL   24'h000000
// field low bits
`define MTEIS_F12_LO      0
`define MTEIS_F13_LO      4
`define MTEIS_F14_LO      8
`define MTEIS_F18_LO      0
`define MTEIS_F19_LO      6
`define MTEIS_F20_LO      12
`define MTEIS_F21_LO      18
`define MTEIS_TWO_USED    12
// status bit of each switch
`define MTEIS_ST12        0
`define MTEIS_ST13        1
`define MTEIS_ST14        2
`define MTEIS_ST18        3
`define MTEIS_ST19        4
`define MTEIS_ST20        5
`define MTEIS_ST21        6
`define MTEIS_NUM_SW      7

`endif

// >>> pkg/mteis_pkg.sv
/*
 * types of the edge-select block.
 * assumes mteis_map.svh is compiled alongside.
 */
package mteis_pkg;
	// two-bit edge choice per limit
	typedef enum logic [1:0]
	{
		MTEIS_EDGE_NONE = 2'h0,
		MTEIS_EDGE_RISE = 2'h1,
		MTEIS_EDGE_FALL = 2'h2,
		MTEIS_EDGE_BOTH = 2'h3
	} mteis_edge_t;
	// apb slave phase
	typedef enum logic [0:0]
	{
		MTEIS_BUS_IDLE,
		MTEIS_BUS_ACCESS
	} mteis_bus_t;
endpackage

// >>> verilog/mteis_crossing.sv
/*
 * crossing detector for one switch against n limits.
 * assumes above bits are synchronous samples, one per limit.
 */
`timescale 1ns/1ps
module mteis_crossing #(
	parameter int LIMITS = 2
) (
	input  wire logic                  pclk,    // device clock
	input  wire logic                  presetn, // async reset, low
	input  wire logic [LIMITS-1:0]     above,   // comparison per limit
	input  wire logic [2*LIMITS-1:0]   sel,     // edge choice per limit
	output logic                       hit      // enabled crossing seen
);
	logic [LIMITS-1:0] prev;

	// decode one two-bit edge choice
	function automatic logic fire(input logic [1:0] s, input logic r, input logic f);
		case (mteis_pkg::mteis_edge_t'(s))
			mteis_pkg::MTEIS_EDGE_RISE: fire = r;     // RULE1 RULE6
			mteis_pkg::MTEIS_EDGE_FALL: fire = f;     // RULE2 RULE7
			mteis_pkg::MTEIS_EDGE_BOTH: fire = r | f; // RULE8
			default:                    fire = 1'b0;  // RULE1
		endcase
	endfunction

	// previous sample per limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev <= '0;
		else
			prev <= above;
	end

	// any selected crossing
	always_comb
	begin
		hit = 1'b0;
		for (int i = 0; i < LIMITS; i++)
			hit = hit | fire(sel[2*i +: 2], above[i] & ~prev[i], ~above[i] & prev[i]); // RULE11
	end
endmodule

// >>> verilog/mteis_apb.sv
/*
 * apb slave front end: access phase flag and register strobes.
 * assumes pclk domain; answers with pready in the access cycle.
 */
`timescale 1ns/1ps
module mteis_apb (
	input  wire logic        pclk,     // device clock
	input  wire logic        presetn,  // async reset, low
	input  wire logic        psel,     // select
	input  wire logic        penable,  // enable
	input  wire logic        pwrite,   // write direction
	input  wire logic [9:0]  paddr,    // byte address
	output logic             wr_stb,   // write takes effect
	output logic             rd_stb,   // read data taken
	output logic [7:0]       index,    // word index
	output logic             aligned   // low two bits zero
);
	mteis_pkg::mteis_bus_t phase;

	// track setup and access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase <= mteis_pkg::MTEIS_BUS_IDLE;
		else
			case (phase)
				mteis_pkg::MTEIS_BUS_IDLE:   phase <= (psel && !penable) ?
					mteis_pkg::MTEIS_BUS_ACCESS : mteis_pkg::MTEIS_BUS_IDLE;
				mteis_pkg::MTEIS_BUS_ACCESS: phase <= mteis_pkg::MTEIS_BUS_IDLE;
				default:                     phase <= mteis_pkg::MTEIS_BUS_IDLE;
			endcase
	end

	// strobes in the access cycle
	assign wr_stb  = (phase == mteis_pkg::MTEIS_BUS_ACCESS) & psel & penable & pwrite;
	assign rd_stb  = (phase == mteis_pkg::MTEIS_BUS_ACCESS) & psel & penable & ~pwrite;
	assign index   = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'h0);
endmodule

// >>> testbench/mteis_top_tb.sv
/*
 * self-checking bench of the edge-select block against a behavioural model.
 * assumes the design files and mteis_map.svh are compiled first.
 */
`timescale 1ns/1ps
`include "mteis_map.svh"
module mteis_top_tb;
	logic        pclk;      // clock
	logic        presetn;   // reset, low
	logic        psel;      // apb select
	logic        penable;   // apb enable
	logic        pwrite;    // apb direction
	logic [9:0]  paddr;     // apb address
	logic [31:0] pwdata;    // apb write data
	logic [31:0] prdata;    // apb read data
	logic        pready;    // apb ready
	logic        pslverr;   // apb error
	logic        irq;       // interrupt
	logic [2:0]  sw [7];    // above bits per switch
	logic [2:0]  pv [7];    // model previous samples
	logic [11:0] two_m;     // model two-level register
	logic [23:0] three_m;   // model three-level register
	logic [6:0]  st_m;      // model status
	logic [6:0]  mk_m;      // model mask
	logic        irq_m;     // model interrupt
	logic [31:0] rd;        // read data taken
	logic        er;        // error taken
	int          errors;    // mismatches
	int          cmp_count; // comparisons
	int          seed;      // random seed
	int          lo [7] = '{`MTEIS_F12_LO, `MTEIS_F13_LO, `MTEIS_F14_LO, `MTEIS_F18_LO,
		`MTEIS_F19_LO, `MTEIS_F20_LO, `MTEIS_F21_LO};
	logic [9:0]  wa [7] = '{10'h098, 10'h09C, 10'h0C0, 10'h0C4, 10'h09A, 10'h0A0, 10'h3FC};

	mteis_top dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.switch_twelve(sw[0][1:0]), .switch_thirteen(sw[1][1:0]),
		.switch_fourteen(sw[2][1:0]), .switch_eighteen(sw[3]), .switch_nineteen(sw[4]),
		.switch_twenty(sw[5]), .switch_twentyone(sw[6]), .irq(irq)
	);

	// clock generation
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	// enabled crossing of one switch against its model select field
	function automatic logic hit(int k);
		logic [23:0] s;
		logic        h;
		s = (k < 3) ? (24'(two_m) >> lo[k]) : (three_m >> lo[k]);
		h = 1'b0;
		for (int l = 0; l < ((k < 3) ? 2 : 3); l++)
			h = h | (s[2*l] & ~pv[k][l] & sw[k][l]) | (s[2*l+1] & pv[k][l] & ~sw[k][l]);
		return h;
	endfunction

	// behavioural model of registers, status and interrupt
	always @(posedge pclk or negedge presetn)
	begin
		logic [6:0] set;
		logic       acc;
		if (!presetn)
		begin
			two_m <= 12'h000;
			three_m <= 24'h000000;
			st_m <= 7'h00;
			mk_m <= 7'h00;
			irq_m <= 1'b0;
			pv <= '{default:3'h0};
		end
		else
		begin
			acc = psel && penable && pwrite;
			for (int k = 0; k < 7; k++)
				set[k] = hit(k);
			pv <= sw;
			if (acc && paddr == 10'h098)
				two_m <= pwdata[11:0];
			if (acc && paddr == 10'h09C)
				three_m <= pwdata[23:0];
			if (acc && paddr == 10'h0C4)
				mk_m <= pwdata[6:0];
			st_m <= (st_m & ~((acc && paddr == 10'h0C0) ? pwdata[6:0] : 7'h00)) | set;
			irq_m <= |(st_m & mk_m);
		end
	end

	function automatic logic [31:0] exp_rd(logic [9:0] a);
		case (a)
			10'h098: return 32'(two_m);
			10'h09C: return 32'(three_m);
			10'h0C0: return 32'(st_m);
			10'h0C4: return 32'(mk_m);
			default: return 32'h00000000;
		endcase
	endfunction

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(logic w, logic [9:0] a, logic [31:0] d);
		logic [31:0] ed;
		logic        ee;
		int          n;
		ee = !(a inside {10'h098, 10'h09C, 10'h0C0, 10'h0C4});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		ed = exp_rd(a);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			errors++;
		check("pslverr", 32'(er), 32'(ee));
		if (!w)
			check("prdata", rd, ed);
	endtask

	// interrupt compared with the model every cycle
	always @(negedge pclk)
		if (presetn === 1'b1)
			check("irq", 32'(irq), 32'(irq_m));

	// main sequence
	initial
	begin
		seed = 32'h5634;
		errors = 0;
		cmp_count = 0;
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 10'h000;
		pwdata <= 32'h00000000;
		sw <= '{default:3'h0};
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, then all ones written everywhere including holes
		for (int i = 0; i < 7; i++)
			apb(1'b0, wa[i], 32'h00000000);
		for (int i = 0; i < 7; i++)
			apb(1'b1, wa[i], 32'hFFFFFFFF);
		for (int i = 0; i < 7; i++)
			apb(1'b0, wa[i], 32'h00000000);
		// every switch, limit and edge choice: rise then fall
		for (int k = 0; k < 7; k++)
			for (int l = 0; l < ((k < 3) ? 2 : 3); l++)
				for (int m = 0; m < 4; m++)
				begin
					apb(1'b1, (k < 3) ? 10'h098 : 10'h09C, 32'(m) << (lo[k] + 2 * l));
					apb(1'b1, 10'h0C0, 32'h0000007F);
					sw[k][l] <= 1'b1;
					repeat (3) @(posedge pclk);
					apb(1'b0, 10'h0C0, 32'h00000000);
					apb(1'b1, 10'h0C0, 32'h0000007F);
					sw[k][l] <= 1'b0;
					repeat (3) @(posedge pclk);
					apb(1'b0, 10'h0C0, 32'h00000000);
				end
		// random selections, mask and switch activity
		apb(1'b1, 10'h098, $random(seed));
		apb(1'b1, 10'h09C, $random(seed));
		apb(1'b1, 10'h0C4, $random(seed));
		for (int i = 0; i < 300; i++)
		begin
			@(posedge pclk);
			sw[i % 7] <= 3'($random(seed));
		end
		repeat (3) @(posedge pclk);
		apb(1'b0, 10'h0C0, 32'h00000000);
		apb(1'b1, 10'h0C0, 32'h0000007F);
		apb(1'b0, 10'h0C0, 32'h00000000);
		// second reset in mid-run clears the selections
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 10'h09C, 32'h00000000);
		apb(1'b0, 10'h098, 32'h00000000);
		stop_test();
	end
endmodule
